// >>> logic/rftim_pkg.sv
package rftim_pkg;

    // Register word indices; each register takes one aligned word at four times its index.
    localparam logic [7:0] RFTIM_IDX_GEN_CTRL = 8'h1e;
    localparam logic [7:0] RFTIM_IDX_RELOAD_HIGH = 8'h1f;
    localparam logic [7:0] RFTIM_IDX_RELOAD_LOW = 8'h20;
    localparam logic [7:0] RFTIM_IDX_COUNT_HIGH = 8'h21;
    localparam logic [7:0] RFTIM_IDX_COUNT_LOW = 8'h22;
    localparam logic [7:0] RFTIM_IDX_WAKE_CTRL = 8'h23;
    localparam logic [7:0] RFTIM_IDX_WAKE_RELOAD_HIGH = 8'h24;
    localparam logic [7:0] RFTIM_IDX_WAKE_RELOAD_LOW = 8'h25;
    localparam logic [7:0] RFTIM_IDX_IRQ_STATUS = 8'h30;
    localparam logic [7:0] RFTIM_IDX_IRQ_MASK = 8'h31;
    localparam int RFTIM_IDX_W = 8;

    // General timer control field positions.
    localparam int RFTIM_GEN_STOP_RX_BIT = 7;
    localparam int RFTIM_GEN_START_LO = 4;
    localparam int RFTIM_GEN_RELOAD_BIT = 3;
    localparam int RFTIM_GEN_CLK_LO = 0;
    localparam logic [7:0] RFTIM_GEN_CTRL_MASK = 8'hbb;

    // Wake-up control field positions.
    localparam int RFTIM_WK_RUN_BIT = 7;
    localparam int RFTIM_WK_QUAL_BIT = 6;
    localparam int RFTIM_WK_TRIM_BIT = 5;
    localparam int RFTIM_WK_CARD_BIT = 4;
    localparam int RFTIM_WK_RELOAD_BIT = 3;
    localparam int RFTIM_WK_WAKE_BIT = 2;

    // Interrupt status bits.
    localparam int RFTIM_IRQ_GEN_BIT = 0;
    localparam int RFTIM_IRQ_WAKE_BIT = 1;
    localparam int RFTIM_IRQ_W = 2;

    // Received bit count after which the general timer may stop.
    localparam logic [2:0] RFTIM_STOP_RX_BITS = 3'h4;

    // Low-frequency oscillator prescale dividers minus one.
    localparam logic [4:0] RFTIM_LFO_DIV1 = 5'h00;
    localparam logic [4:0] RFTIM_LFO_DIV8 = 5'h07;
    localparam logic [4:0] RFTIM_LFO_DIV16 = 5'h0f;
    localparam logic [4:0] RFTIM_LFO_DIV32 = 5'h1f;

    localparam logic [15:0] RFTIM_ZERO16 = 16'h0000;
    localparam logic [15:0] RFTIM_ONE16 = 16'h0001;

    // AHB-Lite encodings.
    localparam logic [1:0] RFTIM_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] RFTIM_HTRANS_SEQ = 2'h3;

    typedef enum logic [1:0] {
        RFTIM_START_NONE = 2'h0,
        RFTIM_START_TX_END = 2'h1,
        RFTIM_START_TRIM = 2'h2,
        RFTIM_START_TRIM_UF = 2'h3
    } rftim_start_t;

    typedef enum logic [1:0] {
        RFTIM_CLK_FAST = 2'h0,
        RFTIM_CLK_DIV = 2'h1,
        RFTIM_CLK_T0 = 2'h2,
        RFTIM_CLK_T1 = 2'h3
    } rftim_clk_t;

    // General timer control byte.
    typedef struct packed {
        logic stop_on_receive;
        logic rsvd6;
        rftim_start_t start_select;
        logic auto_reload_enable;
        logic rsvd2;
        rftim_clk_t clock_select;
    } rftim_gen_ctrl_t;

    // Wake-up control byte.
    typedef struct packed {
        logic wakeup_running;
        logic wakeup_run_change_qualifier;
        logic wakeup_auto_trim;
        logic wakeup_auto_card_detect;
        logic wakeup_auto_reload;
        logic wakeup_auto_wake;
        logic [1:0] wakeup_clock_select;
    } rftim_wake_ctrl_t;

    // Tick sources that arrive from the rest of the frontend.
    typedef struct packed {
        logic fast_tick;
        logic div_tick;
        logic timer0_underflow;
        logic timer1_underflow;
        logic lfo_tick;
    } rftim_ticks_t;

    // Transceiver progress signals.
    typedef struct packed {
        logic tx_end;
        logic rx_bit;
        logic rx_active;
        logic trim_edge;
    } rftim_xcvr_t;

endpackage

// >>> logic/rftim_top.sv
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - Stop-on-receive halts timer after four received bits.
// - Trimming modes ignore the stop-on-receive bit.
// - Start select 00 manual (this design has no start source for 00, so the timer never starts), 01 at transmit end.
// - Trimming modes start and stop on edges.
// - Auto-reload reloads at zero and continues.
// - Without auto-reload, stop at zero until restarted.
// - Each underflow sets the underflow interrupt flag.
// - Clock select 00 fast clock, 01 divided.
// - Clock select 10/11 chain timer0/timer1 underflows.
// - Start event loads counter from reload bytes.
// - Reload writes affect only the next start or auto-reload.
// - Live counter readable as high and low bytes.
// - Wake-up timer wakes system, may start detection.
// - Wake-up control byte field layout.
// - Software changes running bit only with qualifier set.
// - Wake-up clock divides oscillator by 1/8/16/32.
module rftim_top
    import rftim_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire rftim_ticks_t ticks,
    input wire rftim_xcvr_t xcvr,
    output logic irq,
    output logic underflow_pulse,
    output logic wake_request,
    output logic card_detect_start,
    output logic trim_request
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops.
    logic rst_meta_r;
    logic rst_sync_r;

    // The release is synchronised so every flop leaves reset on the same edge.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    wire logic rst_n = rst_sync_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus address phase capture.
    logic wr_pend_r;
    logic [RFTIM_IDX_W-1:0] wr_idx_r;
    logic [RFTIM_IDX_W-1:0] rd_idx;
    logic addr_ok;
    logic rd_take;

    assign addr_ok = hsel && hready && (htrans == RFTIM_HTRANS_NONSEQ || htrans == RFTIM_HTRANS_SEQ);
    assign rd_take = addr_ok && !hwrite;
    assign rd_idx = haddr[RFTIM_IDX_W+1:2];

    // Writes complete in the data phase, so the index is held for one cycle.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend_r <= 1'b0;
            wr_idx_r <= '0;
        end
        else
        begin
            wr_pend_r <= addr_ok && hwrite;
            wr_idx_r <= rd_idx;
        end
    end

    function automatic logic wr_hit(input logic [RFTIM_IDX_W-1:0] idx);
        wr_hit = wr_pend_r && (wr_idx_r == idx);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Software registers.
    rftim_gen_ctrl_t gen_ctrl_r;
    logic [7:0] reload_high_byte_r;
    logic [7:0] reload_low_byte_r;
    rftim_wake_ctrl_t wake_ctrl_r;
    logic [15:0] wake_reload_r;
    logic [RFTIM_IRQ_W-1:0] irq_mask_r;
    logic [RFTIM_IRQ_W-1:0] irq_status_r;

    // Reserved bits are masked away on every write.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gen_ctrl_r <= '0;
            reload_high_byte_r <= '0;
            reload_low_byte_r <= '0;
            wake_reload_r <= '0;
            irq_mask_r <= '0;
        end
        else
        begin
            if (wr_hit(RFTIM_IDX_GEN_CTRL))
                gen_ctrl_r <= hwdata[7:0] & RFTIM_GEN_CTRL_MASK;
            if (wr_hit(RFTIM_IDX_RELOAD_HIGH))
                reload_high_byte_r <= hwdata[7:0];
            if (wr_hit(RFTIM_IDX_RELOAD_LOW))
                reload_low_byte_r <= hwdata[7:0];
            if (wr_hit(RFTIM_IDX_WAKE_RELOAD_HIGH))
                wake_reload_r[15:8] <= hwdata[7:0];
            if (wr_hit(RFTIM_IDX_WAKE_RELOAD_LOW))
                wake_reload_r[7:0] <= hwdata[7:0];
            if (wr_hit(RFTIM_IDX_IRQ_MASK))
                irq_mask_r <= hwdata[RFTIM_IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // General timer start, stop and tick selection.
    logic [15:0] count_r;
    logic running_r;
    logic [2:0] rx_bits_r;
    logic trim_mode;
    logic start_ev;
    logic stop_ev;
    logic tick;
    logic at_one;
    logic uf;

    assign trim_mode = gen_ctrl_r.start_select[1];

    // Receive bit counter restarts with each reception.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rx_bits_r <= '0;
        else if (!xcvr.rx_active)
            rx_bits_r <= '0;
        else if (xcvr.rx_bit && rx_bits_r != RFTIM_STOP_RX_BITS)
            rx_bits_r <= rx_bits_r + 3'h1;
    end

    always_comb
    begin
        start_ev = 1'b0;
        stop_ev = 1'b0;
        unique case (gen_ctrl_r.start_select)
            RFTIM_START_NONE: start_ev = 1'b0;
            RFTIM_START_TX_END: start_ev = xcvr.tx_end;
            RFTIM_START_TRIM, RFTIM_START_TRIM_UF:
            begin
                start_ev = xcvr.trim_edge && !running_r;
                stop_ev = xcvr.trim_edge && running_r;
            end
        endcase
        // The fourth bit stops the count once, in the cycle it arrives.
        if (gen_ctrl_r.stop_on_receive && !trim_mode && xcvr.rx_bit
            && rx_bits_r == RFTIM_STOP_RX_BITS - 3'h1)
            stop_ev = 1'b1;
    end

    always_comb
    begin
        unique case (gen_ctrl_r.clock_select)
            RFTIM_CLK_FAST: tick = ticks.fast_tick;
            RFTIM_CLK_DIV: tick = ticks.div_tick;
            RFTIM_CLK_T0: tick = ticks.timer0_underflow;
            RFTIM_CLK_T1: tick = ticks.timer1_underflow;
        endcase
    end

    assign at_one = count_r == RFTIM_ONE16;
    // No underflow in trimming without underflow, nor when a start or stop wins the cycle.
    assign uf = running_r && tick && (count_r == RFTIM_ZERO16) && !start_ev && !stop_ev
        && gen_ctrl_r.start_select != RFTIM_START_TRIM;

    ////////////////////////////////////////////////////////////////////////////////
    // General timer counter.
    // A start wins over a stop and a tick in the same cycle.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_r <= '0;
            running_r <= 1'b0;
        end
        else if (start_ev)
        begin
            count_r <= {reload_high_byte_r, reload_low_byte_r};
            running_r <= 1'b1;
        end
        else if (stop_ev)
            running_r <= 1'b0;
        else if (running_r && tick)
        begin
            if (count_r != RFTIM_ZERO16)
                count_r <= count_r - RFTIM_ONE16;
            else if (gen_ctrl_r.auto_reload_enable)
                count_r <= {reload_high_byte_r, reload_low_byte_r};
            else
                running_r <= 1'b0;
        end
    end

    // The pulse lasts one clock and can feed a later timer's chain input.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            underflow_pulse <= 1'b0;
        else
            underflow_pulse <= uf;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wake-up timer.
    logic [15:0] wake_count_r;
    logic [4:0] lfo_div_r;
    logic [4:0] lfo_lim;
    logic wake_tick;
    logic wake_uf;
    logic wake_set;

    always_comb
    begin
        unique case (wake_ctrl_r.wakeup_clock_select)
            2'h0: lfo_lim = RFTIM_LFO_DIV1;
            2'h1: lfo_lim = RFTIM_LFO_DIV8;
            2'h2: lfo_lim = RFTIM_LFO_DIV16;
            2'h3: lfo_lim = RFTIM_LFO_DIV32;
        endcase
    end

    assign wake_tick = ticks.lfo_tick && lfo_div_r == lfo_lim;
    assign wake_uf = wake_ctrl_r.wakeup_running && wake_tick && wake_count_r == RFTIM_ZERO16;
    assign wake_set = wr_hit(RFTIM_IDX_WAKE_CTRL) && hwdata[RFTIM_WK_QUAL_BIT];

    // Running changes by software only with the qualifier in the same write.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wake_ctrl_r <= '0;
            wake_count_r <= '0;
            lfo_div_r <= '0;
        end
        else
        begin
            if (wr_hit(RFTIM_IDX_WAKE_CTRL))
            begin
                wake_ctrl_r.wakeup_auto_trim <= hwdata[RFTIM_WK_TRIM_BIT];
                wake_ctrl_r.wakeup_auto_card_detect <= hwdata[RFTIM_WK_CARD_BIT];
                wake_ctrl_r.wakeup_auto_reload <= hwdata[RFTIM_WK_RELOAD_BIT];
                wake_ctrl_r.wakeup_auto_wake <= hwdata[RFTIM_WK_WAKE_BIT];
                wake_ctrl_r.wakeup_clock_select <= hwdata[1:0];
            end
            if (wake_set)
            begin
                wake_ctrl_r.wakeup_running <= hwdata[RFTIM_WK_RUN_BIT];
                wake_count_r <= wake_reload_r;
                lfo_div_r <= '0;
            end
            else if (wake_ctrl_r.wakeup_running && ticks.lfo_tick)
            begin
                lfo_div_r <= wake_tick ? 5'h00 : lfo_div_r + 5'h01;
                if (wake_tick && wake_count_r != RFTIM_ZERO16)
                    wake_count_r <= wake_count_r - RFTIM_ONE16;
                else if (wake_uf)
                begin
                    wake_count_r <= wake_reload_r;
                    if (!wake_ctrl_r.wakeup_auto_reload && !wake_ctrl_r.wakeup_auto_card_detect)
                        wake_ctrl_r.wakeup_running <= 1'b0;
                end
            end
        end
    end

    // Wake-up side effects are one-clock pulses at the wake-up underflow.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wake_request <= 1'b0;
            card_detect_start <= 1'b0;
            trim_request <= 1'b0;
        end
        else
        begin
            wake_request <= wake_uf && wake_ctrl_r.wakeup_auto_wake;
            card_detect_start <= wake_uf && wake_ctrl_r.wakeup_auto_card_detect;
            trim_request <= wake_uf && wake_ctrl_r.wakeup_auto_trim;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status; a new event wins over a write-one clear.
    logic [RFTIM_IRQ_W-1:0] irq_ev;
    logic [RFTIM_IRQ_W-1:0] irq_clr;

    assign irq_ev = {wake_uf, uf};
    assign irq_clr = wr_hit(RFTIM_IDX_IRQ_STATUS) ? hwdata[RFTIM_IRQ_W-1:0] : '0;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_status_r <= '0;
            irq <= 1'b0;
        end
        else
        begin
            irq_status_r <= (irq_status_r & ~irq_clr) | irq_ev;
            irq <= |(((irq_status_r & ~irq_clr) | irq_ev) & irq_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data; the counter value is unreliable while receiving.
    logic [7:0] rd_byte;

    always_comb
    begin
        unique case (rd_idx)
            RFTIM_IDX_GEN_CTRL: rd_byte = gen_ctrl_r;
            RFTIM_IDX_RELOAD_HIGH: rd_byte = reload_high_byte_r;
            RFTIM_IDX_RELOAD_LOW: rd_byte = reload_low_byte_r;
            RFTIM_IDX_COUNT_HIGH: rd_byte = count_r[15:8];
            RFTIM_IDX_COUNT_LOW: rd_byte = count_r[7:0];
            RFTIM_IDX_WAKE_CTRL: rd_byte = {wake_ctrl_r[7], 1'b0, wake_ctrl_r[5:0]};
            RFTIM_IDX_WAKE_RELOAD_HIGH: rd_byte = wake_reload_r[15:8];
            RFTIM_IDX_WAKE_RELOAD_LOW: rd_byte = wake_reload_r[7:0];
            RFTIM_IDX_IRQ_STATUS: rd_byte = {6'h00, irq_status_r};
            RFTIM_IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask_r};
            default: rd_byte = 8'h00;
        endcase
    end

    // Zero-wait slave: read data registered at the address phase edge.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (rd_take)
                hrdata <= {24'h000000, rd_byte};
        end
    end

endmodule

// >>> bench/rftim_props.sv
`timescale 1ns/1ps
// Watches the bus and timer ports of the top module.
module rftim_props
    import rftim_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire rftim_ticks_t ticks,
    input wire logic underflow_pulse
);
    logic rd;
    logic low;
    logic [7:0] ix;
    logic known;
    // Read address phases; high address bits are kept out because the top decodes only haddr[9:2], so they alias.
    assign rd = hsel && hready && htrans[1] && !hwrite;
    assign low = haddr[31:10] == 22'h0;
    assign ix = haddr[9:2];
    assign known = ix inside {[RFTIM_IDX_GEN_CTRL:RFTIM_IDX_WAKE_RELOAD_LOW],
        RFTIM_IDX_IRQ_STATUS, RFTIM_IDX_IRQ_MASK};
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_ready_high: assert property (hreadyout == 1'b1)
        else $error("wait state inserted");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_rdata_hold: assert property (!rd |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (rd && low && !known |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_gen_reserved: assert property (rd && low && ix == RFTIM_IDX_GEN_CTRL
        |=> hrdata[6] == 1'b0 && hrdata[2] == 1'b0)
        else $error("reserved control bits read set");
    a_wake_qual_zero: assert property (rd && low && ix == RFTIM_IDX_WAKE_CTRL
        |=> hrdata[6] == 1'b0)
        else $error("qualifier bit reads set");
    a_uf_has_tick: assert property (underflow_pulse |-> $past(ticks[4:1]) != 4'h0)
        else $error("underflow without a clock tick");
endmodule

bind rftim_top rftim_props rftim_props_inst (.clock(clock), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ticks(ticks), .underflow_pulse(underflow_pulse));

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import rftim_pkg::*;
;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout, hresp, irq, underflow_pulse;
    logic wake_request, card_detect_start, trim_request;
    rftim_ticks_t ticks = '0;
    rftim_xcvr_t xcvr = '0;
    int n_errors = 0;
    int comparisons = 0;
    int n_uf = 0;
    int n_wk = 0;
    int n_tr = 0;
    int n_cd = 0;
    // The stop-on-receive mode goes before the trimming case so that case starts from a stopped timer.
    logic [7:0] modes [4] = '{8'h11, 8'h91, 8'h01, 8'ha1};
    logic [7:0] expv [4] = '{8'h0f, 8'h10, 8'h10, 8'h0f};

    // The single slave drives the bus ready line.
    assign hready = hreadyout;
    always #10 clock = ~clock;

    rftim_top rftim_top_inst (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ticks(ticks), .xcvr(xcvr),
        .irq(irq), .underflow_pulse(underflow_pulse), .wake_request(wake_request),
        .card_detect_start(card_detect_start), .trim_request(trim_request));

    // Counts output pulses so that missing or extra events show up later.
    always @(posedge clock)
    begin
        if (underflow_pulse === 1'b1) n_uf++;
        if (wake_request === 1'b1) n_wk++;
        if (trim_request === 1'b1) n_tr++;
        if (card_detect_start === 1'b1) n_cd++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask

    // One single transfer; each phase is held until ready is seen high at an edge.
    task automatic xfer(input logic [7:0] ix, input logic wr, input logic [7:0] wd,
        output logic [31:0] rd);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {22'h0, ix, 2'h0};
        htrans <= RFTIM_HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clock); while (hreadyout !== 1'b1 && ++n < 100);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge clock); while (hreadyout !== 1'b1 && ++n < 100);
        rd = hrdata;
        if (n >= 100)
        begin
            n_errors++;
            complete_run();
        end
    endtask

    task automatic wr(input logic [7:0] ix, input logic [7:0] d);
        logic [31:0] v;
        xfer(ix, 1'b1, d, v);
    endtask

    task automatic rc(input logic [7:0] ix, input logic [7:0] e);
        logic [31:0] v;
        xfer(ix, 1'b0, 8'h00, v);
        ck(v, {24'h0, e});
    endtask

    // Holds a tick source high for n edges, then lets one idle edge pass before the next call.
    task automatic tk(input rftim_ticks_t t, input int n);
        ticks <= t;
        repeat (n) @(posedge clock);
        ticks <= '0;
        @(posedge clock);
    endtask

    task automatic xv(input rftim_xcvr_t x, input int n);
        xcvr <= x;
        repeat (n) @(posedge clock);
        xcvr <= '0;
        @(posedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Counter bytes are only read while no reception runs.
    initial
    begin
        int u;
        int w;
        int t;
        int g;
        int d;
        logic [7:0] c;
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        repeat (4) @(posedge clock);
        ck({31'h0, irq}, 32'h0);
        rc(8'h40, 8'h00);
        wr(RFTIM_IDX_GEN_CTRL, 8'hff);
        rc(RFTIM_IDX_GEN_CTRL, 8'hbb);
        wr(RFTIM_IDX_RELOAD_HIGH, 8'h01);
        wr(RFTIM_IDX_RELOAD_LOW, 8'h05);
        wr(RFTIM_IDX_GEN_CTRL, 8'h11);
        xv(4'b1000, 1);
        rc(RFTIM_IDX_COUNT_HIGH, 8'h01);
        rc(RFTIM_IDX_COUNT_LOW, 8'h05);
        tk(5'h08, 3);
        tk(5'h10, 4);
        rc(RFTIM_IDX_COUNT_LOW, 8'h02);
        wr(RFTIM_IDX_RELOAD_LOW, 8'h40);
        tk(5'h08, 1);
        rc(RFTIM_IDX_COUNT_LOW, 8'h01);
        wr(RFTIM_IDX_RELOAD_HIGH, 8'h00);
        wr(RFTIM_IDX_RELOAD_LOW, 8'h02);
        u = n_uf;
        xv(4'b1000, 1);
        tk(5'h08, 5);
        rc(RFTIM_IDX_COUNT_LOW, 8'h00);
        ck(32'(n_uf - u), 32'h1);
        rc(RFTIM_IDX_IRQ_STATUS, 8'h01);
        wr(RFTIM_IDX_IRQ_MASK, 8'h01);
        repeat (2) @(posedge clock);
        ck({31'h0, irq}, 32'h1);
        wr(RFTIM_IDX_IRQ_STATUS, 8'h01);
        repeat (2) @(posedge clock);
        ck({31'h0, irq}, 32'h0);
        rc(RFTIM_IDX_IRQ_STATUS, 8'h00);
        wr(RFTIM_IDX_GEN_CTRL, 8'h19);
        xv(4'b1000, 1);
        u = n_uf;
        tk(5'h08, 3);
        rc(RFTIM_IDX_COUNT_LOW, 8'h02);
        ck(32'(n_uf - u), 32'h1);
        // Each clock choice counts only its own source; another source is sent first.
        for (int s = 0; s < 4; s++)
        begin
            wr(RFTIM_IDX_GEN_CTRL, 8'(8'h18 + s));
            xv(4'b1000, 1);
            tk(5'h10 >> ((s + 1) % 4), 1);
            tk(5'h10 >> s, 1);
            rc(RFTIM_IDX_COUNT_LOW, 8'h01);
        end
        wr(RFTIM_IDX_RELOAD_LOW, 8'h10);
        for (int k = 0; k < 4; k++)
        begin
            wr(RFTIM_IDX_GEN_CTRL, modes[k]);
            xv(modes[k][5] ? 4'b0001 : 4'b1000, 1);
            xv(4'b0110, 4);
            tk(5'h08, 1);
            rc(RFTIM_IDX_COUNT_LOW, expv[k]);
        end
        // The timer runs from the trimming start, so this edge must stop it.
        xv(4'b0001, 1);
        tk(5'h08, 1);
        rc(RFTIM_IDX_COUNT_LOW, 8'h0f);
        wr(RFTIM_IDX_IRQ_STATUS, 8'h03);
        wr(RFTIM_IDX_WAKE_RELOAD_HIGH, 8'h00);
        wr(RFTIM_IDX_WAKE_RELOAD_LOW, 8'h01);
        wr(RFTIM_IDX_WAKE_CTRL, 8'hbc);
        rc(RFTIM_IDX_WAKE_CTRL, 8'h3c);
        wr(RFTIM_IDX_WAKE_CTRL, 8'hc0);
        rc(RFTIM_IDX_WAKE_CTRL, 8'h80);
        wr(RFTIM_IDX_WAKE_CTRL, 8'h03);
        rc(RFTIM_IDX_WAKE_CTRL, 8'h83);
        wr(RFTIM_IDX_WAKE_CTRL, 8'h40);
        rc(RFTIM_IDX_WAKE_CTRL, 8'h00);
        // The prescaler restarts at each qualified write, so the wake lands on tick 2d exactly.
        // Card detection keeps the wake-up timer running past its underflow.
        for (int s = 0; s < 4; s++)
        begin
            d = (s == 0) ? 1 : (4 << s);
            w = n_wk;
            t = n_tr;
            g = n_cd;
            c = 8'(8'hc4 + s + ((s == 1) ? 8'h20 : 8'h00) + ((s == 2) ? 8'h10 : 8'h00));
            wr(RFTIM_IDX_WAKE_CTRL, c);
            tk(5'h01, 2 * d - 1);
            repeat (3) @(posedge clock);
            ck(32'(n_wk - w), 32'h0);
            tk(5'h01, d);
            repeat (3) @(posedge clock);
            ck(32'(n_wk - w), 32'h1);
            ck(32'(n_tr - t), (s == 1) ? 32'h1 : 32'h0);
            ck(32'(n_cd - g), (s == 2) ? 32'h1 : 32'h0);
            rc(RFTIM_IDX_WAKE_CTRL, (c & 8'h3f) | ((s == 2) ? 8'h80 : 8'h00));
        end
        rc(RFTIM_IDX_IRQ_STATUS, 8'h02);
        complete_run();
    end

    // Cuts a hung run short.
    initial
    begin
        repeat (60000) @(posedge clock);
        n_errors++;
        complete_run();
    end
endmodule
